// *** logic/cmcd_pkg.sv ***
/*
 * package for the clock mode configuration decoder: register offsets,
 * field positions, reset values, mode codes and the decoded-enable carrier.
 * assumes a classic wishbone slave with 32-bit data and word-aligned byte offsets.
 */
package cmcd_pkg;

    // ========================================================================
    // register byte offsets
    localparam logic [7:0] CMCD_OFS_MODE = 8'h2C;    // mode register, word 11
    localparam logic [7:0] CMCD_OFS_CFG = 8'h00;     // loop, input, crystal controls
    localparam logic [7:0] CMCD_OFS_FEAT = 8'h04;    // holdover, sync, feedback
    localparam logic [7:0] CMCD_OFS_STAT_CFG = 8'h08; // status pin roles
    localparam logic [7:0] CMCD_OFS_STATUS = 8'h0C;  // read-only decoded state

    // ========================================================================
    // field positions
    localparam int CMCD_MODE_LSB = 27;      // mode field 31:27
    localparam int CMCD_MODE_W = 5;
    localparam int CMCD_CFG_SEL_LSB = 0;    // reference select mode 2:0
    localparam int CMCD_CFG_PREA_LSB = 4;   // ref a prediv code 5:4
    localparam int CMCD_CFG_PREB_LSB = 6;   // ref b prediv code 7:6
    localparam int CMCD_CFG_PREC_LSB = 8;   // ref c prediv code 9:8
    localparam int CMCD_CFG_XTAL_BIT = 12;  // crystal enable
    localparam int CMCD_CFG_PROG_BIT = 13;  // programmed, drops startup clocks
    localparam int CMCD_FEAT_HOLD_LSB = 0;  // holdover mode 1:0
    localparam int CMCD_FEAT_FORCE_BIT = 2; // forced holdover
    localparam int CMCD_FEAT_DLDDIS_BIT = 3; // lock loss detect disable
    localparam int CMCD_FEAT_FBEN_BIT = 4;  // feedback mux enable
    localparam int CMCD_FEAT_FBSEL_BIT = 5; // 0 feedback clock, 1 qualifying clock
    localparam int CMCD_FEAT_QUAL_BIT = 6;  // sync qualify
    localparam int CMCD_FEAT_SYNCEN_BIT = 7; // sync enable
    localparam int CMCD_FEAT_OUT2PD_BIT = 8; // output two powerdown
    localparam int CMCD_STCFG_W = 4;         // one role code per status pin

    // ========================================================================
    // reset values
    localparam logic [4:0] CMCD_MODE_RST = 5'h00;       // dual loop, internal osc
    localparam logic [31:0] CMCD_CFG_RST = 32'h00000000;
    localparam logic [31:0] CMCD_FEAT_RST = 32'h00000000;
    localparam logic [31:0] CMCD_STAT_CFG_RST = 32'h00000000;

    // ========================================================================
    // status pin role codes and reference selection modes
    localparam logic [3:0] CMCD_ROLE_HOLD = 4'h0;
    localparam logic [3:0] CMCD_ROLE_LOS = 4'h1;
    localparam logic [3:0] CMCD_ROLE_LOCK = 4'h2;
    localparam logic [3:0] CMCD_ROLE_ALOCK = 4'h3;
    localparam logic [3:0] CMCD_ROLE_DIV = 4'h4;
    localparam logic [3:0] CMCD_ROLE_RAIL = 4'h5;
    localparam logic [3:0] CMCD_ROLE_RDBK = 4'h6;
    localparam logic [3:0] CMCD_ROLE_SELIN = 4'h7;
    localparam logic [2:0] CMCD_SEL_PINS = 3'h3;
    localparam logic [2:0] CMCD_SEL_AUTO = 3'h4;

    // decoded loop and path enables
    typedef struct packed {
        logic first_loop_en;   // first loop powered
        logic second_loop_en;  // second loop powered
        logic ext_osc;         // external oscillator on ref b
        logic zero_delay;      // feedback path into first loop N
        logic dist_en;         // distribution running
    } cmcd_mode_t;

    localparam cmcd_mode_t CMCD_MODE_EN_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

endpackage : cmcd_pkg

// *** logic/cmcd_top.sv ***
/*
 * clock mode configuration decoder: wishbone register file, mode decode,
 * reference selection, pre-divider codes, startup outputs and status pins.
 * assumes one 50 MHz clock, synchronous reset, inputs synchronous to clk_i.
 */
// ============================================================================
`timescale 1ns/100ps

module cmcd_top
    import cmcd_pkg::*;
#(
    parameter int NUM_CH = 6   // distribution channels
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // device state inputs
    input wire logic sync_event_i,
    input wire logic first_loop_lock_i,
    input wire logic holdover_i,
    input wire logic [2:0] ref_los_i,
    input wire logic analog_lock_i,
    input wire logic div_out_i,
    input wire logic rail_flag_i,
    input wire logic readback_bit_i,
    input wire logic [1:0] status_pin_in_i,
    // decoded controls
    output cmcd_mode_t mode_en_o,
    output logic osc_div_avail_o,
    output logic [1:0] active_ref_o,
    output logic [3:0] ref_prediv_a_o,
    output logic [3:0] ref_prediv_b_o,
    output logic [3:0] ref_prediv_c_o,
    output logic ref_b_is_feedback_o,
    output logic ref_b_is_osc_o,
    output logic fb_mux_en_o,
    output logic fb_mux_qual_o,
    output logic crystal_en_o,
    output logic dist_output_four_en_o,
    output logic dist_output_three_en_o,
    output logic buffered_osc_output_en_o,
    output logic delay_load_o,
    output logic [1:0] status_pin_o,
    output logic [1:0] status_pin_oe_o
);

    // ========================================================================
    // registers
    logic [4:0] mode_ff;              // raw mode field
    logic [31:0] cfg_ff;              // loop and input controls
    logic [31:0] feat_ff;             // feature controls
    logic [31:0] stat_cfg_ff;         // status pin roles
    cmcd_mode_t mode_en_ff;           // decoded enables
    cmcd_mode_t nxt_mode_en;
    logic mode_valid;                 // code is a listed mode
    logic mode_wr_ff;                 // full mode write landed
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [1:0] active_ref_ff;
    logic ref_lock_prev_ff;           // for auto switching on lock loss
    logic [1:0] pin_out_ff;
    logic [1:0] pin_oe_ff;
    logic delay_load_ff;
    logic bus_req;
    logic [31:0] rd_mux;

    assign bus_req = cyc_i && stb_i && !ack_ff;
    // ========================================================================
    // byte-lane merge for writes
    function automatic logic [31:0] cmcd_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // prediv code to ratio 1, 2, 4, 8
    function automatic logic [3:0] cmcd_prediv(input logic [1:0] code);
        return 4'h1 << code;
    endfunction

    // ========================================================================
    // wishbone ack: one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    // register writes, taken at the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= CMCD_CFG_RST;
            feat_ff <= CMCD_FEAT_RST;
            stat_cfg_ff <= CMCD_STAT_CFG_RST;
        end else if (bus_req && we_i) begin
            case (adr_i)
                CMCD_OFS_CFG: cfg_ff <= cmcd_merge(cfg_ff, dat_i, sel_i);
                CMCD_OFS_FEAT: feat_ff <= cmcd_merge(feat_ff, dat_i, sel_i);
                CMCD_OFS_STAT_CFG: stat_cfg_ff <= cmcd_merge(stat_cfg_ff, dat_i, sel_i);
                default: ;  // unmapped or read-only: write ignored
            endcase
        end
    end

    // mode field lives in the top byte; only a write carrying that lane counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= CMCD_MODE_RST;
            mode_wr_ff <= 1'b0;
        end else begin
            mode_wr_ff <= 1'b0;
            if (bus_req && we_i && adr_i == CMCD_OFS_MODE && sel_i[3]) begin
                mode_ff <= dat_i[CMCD_MODE_LSB +: CMCD_MODE_W];
                mode_wr_ff <= 1'b1;
            end
        end
    end

    // ========================================================================
    // mode decode
    always_comb begin
        nxt_mode_en = mode_en_ff;
        mode_valid = 1'b1;
        case (mode_ff)
            5'h00: nxt_mode_en = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
            5'h02: nxt_mode_en = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
            5'h03: nxt_mode_en = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
            5'h05: nxt_mode_en = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            5'h06: nxt_mode_en = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            5'h08: nxt_mode_en = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            5'h0B: nxt_mode_en = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
            5'h10: nxt_mode_en = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            default: mode_valid = 1'b0;
        endcase
    end

    // enables update after a complete mode write of a listed mode code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_en_ff <= CMCD_MODE_EN_RST;
        end else if (mode_wr_ff && mode_valid) begin
            mode_en_ff <= nxt_mode_en;
        end
    end

    // ========================================================================
    // reference selection: manual, pin select or automatic on lock loss
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_ref_ff <= 2'h0;
            ref_lock_prev_ff <= 1'b0;
        end else begin
            ref_lock_prev_ff <= first_loop_lock_i;
            case (cfg_ff[CMCD_CFG_SEL_LSB +: 3])
                3'h0, 3'h1, 3'h2: active_ref_ff <= cfg_ff[CMCD_CFG_SEL_LSB +: 2];
                CMCD_SEL_PINS: begin
                    // both pins high means holdover; keep current ref
                    if (status_pin_in_i != 2'h3) begin
                        active_ref_ff <= status_pin_in_i;
                    end
                end
                CMCD_SEL_AUTO: begin
                    // lock loss steps through priority order
                    if (ref_lock_prev_ff && !first_loop_lock_i
                            && !feat_ff[CMCD_FEAT_DLDDIS_BIT]) begin
                        active_ref_ff <= (active_ref_ff == 2'h2) ? 2'h0 : active_ref_ff + 2'h1;
                    end
                end
                default: ;  // unused codes keep the reference
            endcase
        end
    end

    // ========================================================================
    // path controls; the compare dividers themselves sit outside
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_b_is_feedback_o <= 1'b0;
            ref_b_is_osc_o <= 1'b0;
            osc_div_avail_o <= 1'b1;
            fb_mux_en_o <= 1'b0;
            fb_mux_qual_o <= 1'b0;
            crystal_en_o <= 1'b0;
        end else begin
            ref_b_is_osc_o <= mode_en_ff.ext_osc;
            ref_b_is_feedback_o <= mode_en_ff.zero_delay && !mode_en_ff.ext_osc;
            // no osc divider with external osc
            osc_div_avail_o <= !mode_en_ff.ext_osc;
            // feedback mux only while the first loop is powered
            fb_mux_en_o <= feat_ff[CMCD_FEAT_FBEN_BIT] && mode_en_ff.first_loop_en;
            fb_mux_qual_o <= feat_ff[CMCD_FEAT_FBSEL_BIT];
            crystal_en_o <= cfg_ff[CMCD_CFG_XTAL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_prediv_a_o <= 4'h1;
            ref_prediv_b_o <= 4'h1;
            ref_prediv_c_o <= 4'h1;
        end else begin
            ref_prediv_a_o <= cmcd_prediv(cfg_ff[CMCD_CFG_PREA_LSB +: 2]);
            ref_prediv_b_o <= cmcd_prediv(cfg_ff[CMCD_CFG_PREB_LSB +: 2]);
            ref_prediv_c_o <= cmcd_prediv(cfg_ff[CMCD_CFG_PREC_LSB +: 2]);
        end
    end

    // ========================================================================
    // startup clocks and delay load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dist_output_four_en_o <= 1'b1;
            dist_output_three_en_o <= 1'b1;
            buffered_osc_output_en_o <= 1'b1;
            delay_load_ff <= 1'b0;
        end else begin
            dist_output_four_en_o <= !cfg_ff[CMCD_CFG_PROG_BIT];
            dist_output_three_en_o <= !cfg_ff[CMCD_CFG_PROG_BIT] && !cfg_ff[CMCD_CFG_XTAL_BIT];
            buffered_osc_output_en_o <= !cfg_ff[CMCD_CFG_PROG_BIT] && !cfg_ff[CMCD_CFG_XTAL_BIT];
            delay_load_ff <= sync_event_i && mode_en_ff.dist_en;
        end
    end

    // ========================================================================
    // status pins: each pin picks a role from its four-bit code
    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            logic [3:0] role;
            assign role = stat_cfg_ff[p*CMCD_STCFG_W +: CMCD_STCFG_W];
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_out_ff[p] <= 1'b0;
                    pin_oe_ff[p] <= 1'b1;
                end else begin
                    pin_oe_ff[p] <= (role != CMCD_ROLE_SELIN);
                    case (role)
                        CMCD_ROLE_HOLD: pin_out_ff[p] <= holdover_i;
                        CMCD_ROLE_LOS: pin_out_ff[p] <= ref_los_i[p];
                        CMCD_ROLE_LOCK: pin_out_ff[p] <= first_loop_lock_i;
                        CMCD_ROLE_ALOCK: pin_out_ff[p] <= analog_lock_i;
                        CMCD_ROLE_DIV: pin_out_ff[p] <= div_out_i;
                        CMCD_ROLE_RAIL: pin_out_ff[p] <= rail_flag_i;
                        CMCD_ROLE_RDBK: pin_out_ff[p] <= readback_bit_i;
                        default: pin_out_ff[p] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // ========================================================================
    // read data; mode readback only once a readback pin is configured
    always_comb begin
        rd_mux = 32'h00000000;
        case (adr_i)
            CMCD_OFS_MODE: begin
                if (stat_cfg_ff[3:0] == CMCD_ROLE_RDBK || stat_cfg_ff[7:4] == CMCD_ROLE_RDBK) begin
                    rd_mux[CMCD_MODE_LSB +: CMCD_MODE_W] = mode_ff;
                end
            end
            CMCD_OFS_CFG: rd_mux = cfg_ff;
            CMCD_OFS_FEAT: rd_mux = feat_ff;
            CMCD_OFS_STAT_CFG: rd_mux = stat_cfg_ff;
            CMCD_OFS_STATUS: rd_mux = {24'h000000, active_ref_ff, 1'b0, mode_en_ff};
            default: rd_mux = 32'h00000000;  // unmapped reads zero
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h00000000;
        end else if (bus_req) begin
            dat_ff <= rd_mux;
        end
    end
    // outputs straight from flip-flops
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;
    assign mode_en_o = mode_en_ff;
    assign active_ref_o = active_ref_ff;
    assign delay_load_o = delay_load_ff;
    assign status_pin_o = pin_out_ff;
    assign status_pin_oe_o = pin_oe_ff;
endmodule // cmcd_top

// *** testbench/cmcd_top_sva.sv ***
/* checker for cmcd_top: bus handshake, mode decode, derived paths, sync.
   assumes it is bound to cmcd_top and sees only that module's ports. */
`timescale 1ns/100ps
module cmcd_top_sva
    import cmcd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic ack_o,
    // device inputs and decoded outputs
    input wire logic sync_event_i,
    input wire cmcd_mode_t mode_en_o,
    input wire logic osc_div_avail_o,
    input wire logic ref_b_is_osc_o,
    input wire logic fb_mux_en_o,
    input wire logic crystal_en_o,
    input wire logic dist_output_three_en_o,
    input wire logic buffered_osc_output_en_o,
    input wire logic delay_load_o
);
    // ========================================================================
    // assertions, one clock domain
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack stood longer than one cycle");
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in the next cycle");
    // enables only move one edge after an acked write to the mode word
    chk_mode_after_write: assert property ($changed(mode_en_o) |->
        $past(ack_o) && $past(we_i) && $past(adr_i) == CMCD_OFS_MODE)
        else $error("mode enables changed without a mode write");
    chk_loop_nesting: assert property (mode_en_o.first_loop_en |-> mode_en_o.second_loop_en)
        else $error("first loop on without second loop");
    chk_ext_loop: assert property (mode_en_o.ext_osc |-> mode_en_o.second_loop_en)
        else $error("external oscillator without second loop");
    chk_dist_on: assert property (mode_en_o.dist_en)
        else $error("distribution disabled");
    chk_osc_path: assert property ($stable(mode_en_o) |->
        osc_div_avail_o == !mode_en_o.ext_osc && ref_b_is_osc_o == mode_en_o.ext_osc)
        else $error("oscillator path does not follow mode");
    chk_fb_gate: assert property (fb_mux_en_o |-> $past(mode_en_o.first_loop_en))
        else $error("feedback mux on with first loop off");
    chk_crystal_cut: assert property (crystal_en_o && $past(crystal_en_o) |->
        !dist_output_three_en_o && !buffered_osc_output_en_o)
        else $error("startup oscillator outputs run in crystal mode");
    chk_delay_load: assert property (sync_event_i && mode_en_o.dist_en |=> delay_load_o)
        else $error("sync event did not load delays");
    chk_no_load: assert property (!sync_event_i |=> !delay_load_o)
        else $error("delays loaded without sync event");

    // main scenarios reached
    cover property (mode_en_o.ext_osc && !mode_en_o.first_loop_en);
    cover property (delay_load_o);
    cover property (fb_mux_en_o);
endmodule // cmcd_top_sva

bind cmcd_top cmcd_top_sva cmcd_top_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .ack_o(ack_o), .sync_event_i(sync_event_i), .mode_en_o(mode_en_o),
    .osc_div_avail_o(osc_div_avail_o), .ref_b_is_osc_o(ref_b_is_osc_o),
    .fb_mux_en_o(fb_mux_en_o), .crystal_en_o(crystal_en_o),
    .dist_output_three_en_o(dist_output_three_en_o),
    .buffered_osc_output_en_o(buffered_osc_output_en_o), .delay_load_o(delay_load_o)
);

// *** testbench/cmcd_host.sv ***
/* host model: classic wishbone master that programs the decoder.
   assumes a slave that acks each request; bench calls task xfer. */
`timescale 1ns/100ps
module cmcd_host (
    // clock
    input wire logic clk_i,
    // slave answer
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    // request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // ========================================================================
    // idle bus at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end

    // values from bench tables
    // one classic cycle, held until ack; bounded wait flags a hang via ok
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic ok);
        ok = 1'b0;
        q = 32'h00000000;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(posedge clk_i);
            ok = ack_i;
            q = dat_i;
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // released data bus shows no stale value
        dat_o <= ~d;
    endtask
endmodule // cmcd_host

// *** testbench/cmcd_top_bench.sv ***
/* self-checking bench for cmcd_top, driven through the host model.
   assumes a 50 MHz clock and sixteen cycles of reset at start. */
`timescale 1ns/100ps
module cmcd_top_bench
    import cmcd_pkg::*;
;
    // ========================================================================
    // stimulus and observed signals
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic sync_ev = 1'b0, lock = 1'b0, rb_bit = 1'b0;
    logic [1:0] pin_in = 2'b10;
    cmcd_mode_t mode_en_o;
    logic osc_div_avail_o, ref_b_is_feedback_o, ref_b_is_osc_o, fb_mux_en_o, fb_mux_qual_o;
    logic crystal_en_o, out4_en, out3_en, bosc_en, delay_load_o;
    logic [1:0] active_ref_o, status_pin_o, status_pin_oe_o;
    logic [3:0] pre_a, pre_b, pre_c;
    int fails = 0;
    int samples_checked = 0;
    // {code, expected enables} for every documented mode
    localparam logic [9:0] MODE_TBL [8] = '{10'h019, 10'h05B, 10'h07D, 10'h0BF,
                                            10'h0C9, 10'h10B, 10'h16D, 10'h201};

    always #10 clk_i = ~clk_i;

    cmcd_host cmcd_host_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    cmcd_top cmcd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .sync_event_i(sync_ev), .first_loop_lock_i(lock), .holdover_i(1'b0),
        .ref_los_i(3'h0), .analog_lock_i(1'b0), .div_out_i(1'b0), .rail_flag_i(1'b0),
        .readback_bit_i(rb_bit), .status_pin_in_i(pin_in), .mode_en_o(mode_en_o),
        .osc_div_avail_o(osc_div_avail_o), .active_ref_o(active_ref_o),
        .ref_prediv_a_o(pre_a), .ref_prediv_b_o(pre_b), .ref_prediv_c_o(pre_c),
        .ref_b_is_feedback_o(ref_b_is_feedback_o), .ref_b_is_osc_o(ref_b_is_osc_o),
        .fb_mux_en_o(fb_mux_en_o), .fb_mux_qual_o(fb_mux_qual_o), .crystal_en_o(crystal_en_o),
        .dist_output_four_en_o(out4_en), .dist_output_three_en_o(out3_en),
        .buffered_osc_output_en_o(bosc_en), .delay_load_o(delay_load_o),
        .status_pin_o(status_pin_o), .status_pin_oe_o(status_pin_oe_o));

    // ========================================================================
    // reporting and access helpers
    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask

    // a hung bus ends the run at once
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        logic ok;
        cmcd_host_inst.xfer(w, a, d, s, q, ok);
        if (ok !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    // enables one edge after ack, derived paths one more
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // ========================================================================
    // scenarios
    // startup outputs
    task automatic t_reset();
        chk_out(32'(mode_en_o), 32'h00000019);
        chk_out(32'({out4_en, out3_en, bosc_en, osc_div_avail_o}), 32'h0000000F);
        chk_out(32'({pre_a, pre_b, pre_c}), 32'h00000111);
        chk_out(32'(status_pin_oe_o), 32'h00000003);
    endtask

    task automatic t_modes();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, CMCD_OFS_MODE, {MODE_TBL[i][9:5], 27'h0000000}, 4'hF, q);
            settle();
            chk_out(32'(mode_en_o), 32'(MODE_TBL[i][4:0]));
            chk_out(32'({osc_div_avail_o, ref_b_is_osc_o, ref_b_is_feedback_o}),
                    32'({~MODE_TBL[i][2], MODE_TBL[i][2], MODE_TBL[i][1] & ~MODE_TBL[i][2]}));
        end
    endtask

    task automatic t_reserved();
        logic [31:0] q;
        acc(1'b1, CMCD_OFS_MODE, 32'h28000000, 4'hF, q);
        settle();
        acc(1'b1, CMCD_OFS_MODE, 32'h08000000, 4'hF, q);
        settle();
        chk_out(32'(mode_en_o), 32'h0000001F);
        acc(1'b1, CMCD_OFS_MODE, 32'h30000000, 4'h7, q);
        settle();
        chk_out(32'(mode_en_o), 32'h0000001F);
    endtask

    task automatic t_readback();
        logic [31:0] q;
        acc(1'b0, CMCD_OFS_MODE, 32'h00000000, 4'hF, q);
        chk_rd(q, 32'h00000000);
        acc(1'b1, CMCD_OFS_STAT_CFG, 32'h00000076, 4'hF, q);
        rb_bit <= 1'b1;
        settle();
        acc(1'b0, CMCD_OFS_MODE, 32'h00000000, 4'hF, q);
        chk_rd(q & 32'hF8000000, 32'h08000000);
        chk_out(32'({status_pin_oe_o, status_pin_o[0]}), 32'h00000003);
        acc(1'b0, CMCD_OFS_STATUS, 32'h00000000, 4'hF, q);
        chk_rd(q, 32'h0000001F);
        acc(1'b0, 8'h40, 32'h00000000, 4'hF, q);
        chk_rd(q, 32'h00000000);
        lock <= 1'b1;
        acc(1'b1, CMCD_OFS_STAT_CFG, 32'h00000026, 4'hF, q);
        settle();
        chk_out(32'({status_pin_oe_o, status_pin_o}), 32'h0000000F);
    endtask

    task automatic t_cfg();
        logic [31:0] q;
        acc(1'b1, CMCD_OFS_CFG, 32'h00001271, 4'hF, q);
        settle();
        chk_out(32'({active_ref_o, pre_a, pre_b, pre_c}), 32'h00001824);
        chk_out(32'({crystal_en_o, out4_en, out3_en, bosc_en}), 32'h0000000C);
        acc(1'b1, CMCD_OFS_CFG, 32'h00000002, 4'hF, q);
        settle();
        chk_out(32'({active_ref_o, pre_a, pre_b, pre_c}), 32'h00002111);
        chk_out(32'({crystal_en_o, out4_en, out3_en, bosc_en}), 32'h00000007);
        // pin select mode, programmed: startup clocks stop
        acc(1'b1, CMCD_OFS_CFG, 32'h00002003, 4'hF, q);
        settle();
        chk_out(32'({active_ref_o, out4_en, out3_en, bosc_en}), 32'h00000010);
        pin_in <= 2'b01;
        settle();
        chk_out(32'(active_ref_o), 32'h00000001);
        // automatic mode: each lock loss steps the reference, c wraps to a
        acc(1'b1, CMCD_OFS_CFG, 32'h00002004, 4'hF, q);
        lock <= 1'b0;
        settle();
        chk_out(32'(active_ref_o), 32'h00000002);
        lock <= 1'b1;
        settle();
        lock <= 1'b0;
        settle();
        chk_out(32'(active_ref_o), 32'h00000000);
    endtask

    // host setup, feedback mux and sync
    task automatic t_feat();
        logic [31:0] q;
        acc(1'b1, CMCD_OFS_MODE, 32'h10000000, 4'hF, q);
        acc(1'b1, CMCD_OFS_FEAT, 32'h000000F2, 4'hF, q);
        settle();
        chk_out(32'({fb_mux_en_o, fb_mux_qual_o}), 32'h00000003);
        @(posedge clk_i);
        sync_ev <= 1'b1;
        @(posedge clk_i);
        sync_ev <= 1'b0;
        #1;
        chk_out(32'(delay_load_o), 32'h00000001);
        acc(1'b1, CMCD_OFS_MODE, 32'h40000000, 4'hF, q);
        settle();
        chk_out(32'({mode_en_o, fb_mux_en_o}), 32'h00000016);
    endtask

    // ========================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset();
        t_modes();
        t_reserved();
        t_readback();
        t_cfg();
        t_feat();
        give_verdict();
    end
endmodule // cmcd_top_bench
